// >>> logic/twp_unpack.sv
// Transmit word unpacker: wide fabric word to per-character encoder feed
//
// Contract
// [R1] 8-bit: character byte on bits 7:0
// [R2] 8-bit: bit 8 marks control character
// [R3] 8-bit: bit 9 force disparity or compliance
// [R4] 8-bit: bit 10 disparity value or idle
// [R5] 10-bit: raw word on 9:0, no flags
// [R6] 16-bit: characters on 7:0 and 18:11
// [R7] 16-bit: control flags bits 8 and 19
// [R8] 16-bit: force enables 9 and 20; bit 20 is dropped in PIPE mode
// [R9] 16-bit: disparity values 10 and 21
// [R10] 20-bit: words on 9:0 and 20:11
// [R11] Control flag only on valid K bytes; the unpacker passes bits 8 and 19 through without checking the byte
// [R12] Unassigned bits zero, ignored by channel
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "twp_cfg.svh"
module twp_unpack (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic [21:0] word_data,
  output logic             sym_valid,
  input  wire logic        sym_ready,
  output logic      [9:0]  sym_data,
  output logic             sym_ctrl,
  output logic             sym_force,
  output logic             sym_disp,
  output logic             sym_idle
);
  localparam int W = `TWP_WORD_W;
  // Config register: [1:0] width, [2] 8B/10B enable, [3] PIPE mode
  logic [31:0]             cfg_reg;
  logic [31:0]             count_reg;
  logic [31:0]             count_next;
  logic [W-1:0]            last_reg;
  logic                    unused_reg;
  twp_pkg::twp_state_t     st_reg;
  twp_pkg::twp_state_t     st_next;
  logic [9:0]              sym_data_next;
  logic                    ctrl_next;
  logic                    force_next;
  logic                    disp_next;
  logic                    idle_next;
  logic                    out_valid_reg;
  logic [9:0]              sym_data_reg;
  logic                    ctrl_reg;
  logic                    force_reg;
  logic                    disp_reg;
  logic                    idle_reg;

  wire twp_pkg::twp_width_t width_sel = twp_pkg::twp_width_t'(cfg_reg[1:0]);
  wire        enc_mode  = cfg_reg[2] &
                          (width_sel == twp_pkg::TWP_W8 ||
                           width_sel == twp_pkg::TWP_W16);
  wire        pipe_mode = cfg_reg[3];
  wire        dual      = (width_sel == twp_pkg::TWP_W16 ||
                           width_sel == twp_pkg::TWP_W20);

  // FIFO decouples fabric bursts from the one-character-per-cycle drain
  wire          f_valid;
  wire          f_pop;
  wire [W-1:0]  f_data;
  wire [5:0]    f_level;
  twp_fifo #(.WIDTH(W), .DEPTH(`TWP_FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .in_data   (word_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data),
    .level     (f_level)
  );

  // Mask of bits that carry meaning at the current width and mode
  function automatic logic [W-1:0] used_mask(input twp_pkg::twp_width_t w,
                                             input logic enc);
    logic [W-1:0] m;
    m = '0;
    case (w)
      twp_pkg::TWP_W8:  m = enc ? 22'h0007ff : 22'h0000ff;
      twp_pkg::TWP_W10: m = 22'h0003ff;
      twp_pkg::TWP_W16: m = enc ? 22'h3fffff : 22'h07f8ff;
      twp_pkg::TWP_W20: m = 22'h1ffbff;
      default:          m = '0;
    endcase
    return m;
  endfunction

  wire [W-1:0] mask   = used_mask(width_sel, enc_mode);
  wire [W-1:0] clean  = f_data & mask;                             // R12
  // 10-bit words have no flag bit 10; slot 10 masked for them
  wire [10:0]  lo_slot = {clean[`TWP_LO_DVAL], clean[`TWP_LO_FDIS:0]};  // R1 R5
  wire [10:0]  hi_slot = clean[`TWP_HI_DVAL:`TWP_HI_LSB];          // R6 R10

  wire [9:0] lo_sym;
  wire       lo_ctrl;
  wire       lo_force;
  wire       lo_disp;
  wire       lo_idle;
  wire [9:0] hi_sym;
  wire       hi_ctrl;
  wire       hi_force;
  wire       hi_disp;
  wire       hi_idle;
  twp_slice u_lo (
    .slot      (lo_slot),
    .enc_mode  (enc_mode),
    .pipe_mode (pipe_mode),
    .sym       (lo_sym),
    .is_ctrl   (lo_ctrl),    // R2 R7
    .force_en  (lo_force),   // R3 R8
    .disp_val  (lo_disp),    // R4 R9
    .elec_idle (lo_idle)
  );
  twp_slice u_hi (
    .slot      (hi_slot),
    .enc_mode  (enc_mode),
    .pipe_mode (pipe_mode),
    .sym       (hi_sym),
    .is_ctrl   (hi_ctrl),
    .force_en  (hi_force),
    .disp_val  (hi_disp),
    .elec_idle (hi_idle)
  );

  // In PIPE mode the upper force bit is reserved and dropped
  wire hi_force_eff = hi_force & ~pipe_mode;                       // R8
  // Electrical idle from either lane holds for the whole word
  wire word_idle = lo_idle | (dual & hi_idle);                     // R9
  wire unused_set = |(f_data & ~mask);                             // R12

  wire out_free = ~out_valid_reg | sym_ready;
  wire load     = f_valid & out_free;
  assign f_pop  = load & (~dual | st_reg == twp_pkg::TWP_ST_HALF);

  always_comb begin
    st_next       = st_reg;
    sym_data_next = sym_data_reg;
    ctrl_next     = ctrl_reg;
    force_next    = force_reg;
    disp_next     = disp_reg;
    idle_next     = idle_reg;
    if (load) begin
      case (st_reg)
        twp_pkg::TWP_ST_IDLE: begin
          // Lower character always leaves first
          sym_data_next = lo_sym;
          ctrl_next     = lo_ctrl;
          force_next    = lo_force;
          disp_next     = lo_disp;
          idle_next     = word_idle;
          if (dual) st_next = twp_pkg::TWP_ST_HALF;
        end
        twp_pkg::TWP_ST_HALF: begin
          sym_data_next = hi_sym;
          ctrl_next     = hi_ctrl;
          force_next    = hi_force_eff;
          disp_next     = hi_disp;
          idle_next     = word_idle;
          st_next       = twp_pkg::TWP_ST_IDLE;
        end
        default: st_next = twp_pkg::TWP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= twp_pkg::TWP_ST_IDLE;
      out_valid_reg <= 1'b0;
      sym_data_reg  <= '0;
      ctrl_reg      <= 1'b0;
      force_reg     <= 1'b0;
      disp_reg      <= 1'b0;
      idle_reg      <= 1'b0;
    end else begin
      st_reg        <= st_next;
      out_valid_reg <= load | (out_valid_reg & ~sym_ready);
      sym_data_reg  <= sym_data_next;
      ctrl_reg      <= ctrl_next;
      force_reg     <= force_next;
      disp_reg      <= disp_next;
      idle_reg      <= idle_next;
    end
  end

  assign sym_valid = out_valid_reg;
  assign sym_data  = sym_data_reg;
  assign sym_ctrl  = ctrl_reg;
  assign sym_force = force_reg;
  assign sym_disp  = disp_reg;
  assign sym_idle  = idle_reg;

  // APB slave, zero wait states
  wire apb_acc = psel & penable;
  wire apb_wr  = apb_acc & pwrite;
  wire hit_cfg   = (paddr == `TWP_OFF_CFG);
  wire hit_stat  = (paddr == `TWP_OFF_STAT);
  wire hit_count = (paddr == `TWP_OFF_COUNT);
  wire hit_last  = (paddr == `TWP_OFF_LAST);
  wire hit_any   = hit_cfg | hit_stat | hit_count | hit_last;
  wire clr_unused = apb_wr & hit_stat & pwdata[0];
  assign count_next = count_reg + 32'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg    <= `TWP_CFG_RST;
      count_reg  <= '0;
      last_reg   <= '0;
      unused_reg <= 1'b0;
    end else begin
      if (apb_wr & hit_cfg) cfg_reg <= {28'h0, pwdata[3:0]};
      if (apb_wr & hit_count) count_reg <= '0;
      else if (f_pop) count_reg <= count_next;
      if (f_pop) last_reg <= f_data;
      // Set wins over a simultaneous software clear
      if (f_pop & unused_set) unused_reg <= 1'b1;                  // R12
      else if (clr_unused) unused_reg <= 1'b0;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~hit_any;
  assign prdata  = hit_cfg   ? cfg_reg :
                   hit_stat  ? {16'h0, 2'h0, f_level, 4'h0,
                                f_valid, out_valid_reg,
                                st_reg == twp_pkg::TWP_ST_HALF, unused_reg} :
                   hit_count ? count_reg :
                   hit_last  ? {10'h0, last_reg} : 32'h0;

  // The character checks look one edge after a load, at the character it produced
  chk_lo_ctrl_flag: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    load && st_reg == twp_pkg::TWP_ST_IDLE && enc_mode |=>
    sym_ctrl == $past(f_data[`TWP_LO_CTRL]))
    else $error("lower control flag mismatch");
  chk_hi_ctrl_flag: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    load && st_reg == twp_pkg::TWP_ST_HALF && enc_mode |=>
    sym_ctrl == $past(f_data[`TWP_HI_CTRL]))
    else $error("upper control flag mismatch");
  chk_lo_byte_map: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    load && st_reg == twp_pkg::TWP_ST_IDLE && enc_mode |=>
    sym_data == {2'h0, $past(f_data[7:0])})
    else $error("lower byte mismatch");
  chk_hi_byte_map: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    load && st_reg == twp_pkg::TWP_ST_HALF && enc_mode |=>
    sym_data == {2'h0, $past(f_data[18:11])})
    else $error("upper byte mismatch");
  chk_w16_raw_upper: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    load && !enc_mode && width_sel == twp_pkg::TWP_W16 &&
    st_reg == twp_pkg::TWP_ST_HALF |=>
    sym_data == {2'h0, $past(f_data[18:11])})
    else $error("upper byte mismatch without encoding");
  chk_raw_word_map: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    load && !enc_mode && st_reg == twp_pkg::TWP_ST_IDLE |=>
    sym_data == ($past(cfg_reg[0]) ? $past(f_data[9:0]) :
                 {2'h0, $past(f_data[7:0])}) &&
    !sym_ctrl && !sym_force)
    else $error("raw lower word mismatch");
  chk_raw_no_flags: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    load && !enc_mode |=>
    !sym_ctrl && !sym_force && !sym_disp && !sym_idle)
    else $error("flag set without encoding");
  chk_raw_hi_map: assert property ( // R10
    @(posedge pclk) disable iff (!presetn)
    load && width_sel == twp_pkg::TWP_W20 &&
    st_reg == twp_pkg::TWP_ST_HALF |=>
    sym_data == $past(f_data[20:11]))
    else $error("raw upper word mismatch");
  chk_pop_order: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    f_pop && dual |-> st_reg == twp_pkg::TWP_ST_HALF)
    else $error("two-character word popped before its upper half");
  chk_force_flag: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    load && enc_mode && st_reg == twp_pkg::TWP_ST_IDLE |=>
    sym_force == $past(f_data[`TWP_LO_FDIS]))
    else $error("force flag mismatch");
  chk_hi_force_flag: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    load && enc_mode && !pipe_mode && st_reg == twp_pkg::TWP_ST_HALF |=>
    sym_force == $past(f_data[`TWP_HI_FDIS]))
    else $error("upper force flag mismatch");
  chk_pipe_hi_force: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    load && pipe_mode && st_reg == twp_pkg::TWP_ST_HALF |=>
    !sym_force)
    else $error("upper force set in PIPE mode");
  chk_lo_disp_value: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    load && enc_mode && !pipe_mode && st_reg == twp_pkg::TWP_ST_IDLE |=>
    sym_disp == $past(f_data[`TWP_LO_DVAL]) && !sym_idle)
    else $error("lower disparity value mismatch");
  chk_disp_value: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    load && enc_mode && !pipe_mode && st_reg == twp_pkg::TWP_ST_HALF |=>
    sym_disp == $past(f_data[`TWP_HI_DVAL]) && !sym_idle)
    else $error("upper disparity value mismatch");
  chk_pipe_idle: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    load && enc_mode && pipe_mode && st_reg == twp_pkg::TWP_ST_IDLE |=>
    sym_idle == ($past(f_data[`TWP_LO_DVAL]) |
                 ($past(dual) & $past(f_data[`TWP_HI_DVAL]))) &&
    !sym_disp)
    else $error("electrical idle mismatch");
  chk_pipe_hi_idle: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    load && enc_mode && pipe_mode && st_reg == twp_pkg::TWP_ST_HALF |=>
    sym_idle == $past(f_data[`TWP_LO_DVAL] | f_data[`TWP_HI_DVAL]) &&
    !sym_disp)
    else $error("upper electrical idle mismatch");
  chk_unused_sticky: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    f_pop && enc_mode && width_sel == twp_pkg::TWP_W8 &&
    (|f_data[21:11]) |=> unused_reg)
    else $error("unused bits not flagged");
  chk_sym_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    sym_valid && !sym_ready |=>
    sym_valid && $stable({sym_data, sym_ctrl, sym_force, sym_disp, sym_idle}))
    else $error("character changed while stalled");
  chk_count_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    f_pop && !(apb_wr && hit_count) |=> count_reg == $past(count_reg) + 32'h1)
    else $error("consumed word count did not step");
endmodule // twp_unpack
`default_nettype wire

// >>> logic/twp_cfg.svh
// Bit positions, register offsets and reset values of the word unpacker
`ifndef TWP_CFG_SVH
`define TWP_CFG_SVH
`define TWP_WORD_W        22
`define TWP_LO_DATA_MSB   7
`define TWP_LO_CTRL       8
`define TWP_LO_FDIS       9
`define TWP_LO_DVAL       10
`define TWP_HI_LSB        11
`define TWP_HI_DATA_MSB   18
`define TWP_HI_CTRL       19
`define TWP_HI_FDIS       20
`define TWP_HI_DVAL       21
`define TWP_W10_MSB       9
`define TWP_HI10_MSB      20
`define TWP_FIFO_DEPTH    32
`define TWP_OFF_CFG       12'h000
`define TWP_OFF_STAT      12'h004
`define TWP_OFF_COUNT     12'h008
`define TWP_OFF_LAST      12'h00c
`define TWP_CFG_RST       32'h0000_0000
`endif

// >>> logic/twp_pkg.sv
// Types shared by the transmit word unpacker
package twp_pkg;
  typedef enum logic [1:0] {
    TWP_W8, TWP_W10, TWP_W16, TWP_W20
  } twp_width_t;
  typedef enum logic {
    TWP_ST_IDLE, TWP_ST_HALF
  } twp_state_t;
endpackage

// >>> logic/twp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module twp_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push;
  wire              pop;
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_reg];
  assign level     = cnt_reg;
  always_ff @(posedge pclk) begin
    if (push) mem_reg[wr_reg] <= in_data;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  chk_fifo_no_overrun: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
  chk_fifo_full_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_reg == (AW+1)'(DEPTH)) == !in_ready)
    else $error("fifo full flag wrong");
endmodule // twp_fifo
`default_nettype wire

// >>> logic/twp_slice.sv
// Splits one character slot of the wide word into its fields
`timescale 1ns/1ps
`default_nettype none
module twp_slice (
  input  wire logic [10:0] slot,
  input  wire logic        enc_mode,
  input  wire logic        pipe_mode,
  output logic      [9:0]  sym,
  output logic             is_ctrl,
  output logic             force_en,
  output logic             disp_val,
  output logic             elec_idle
);
  // Raw 10-bit words carry no flags
  assign sym       = enc_mode ? {2'h0, slot[7:0]} : slot[9:0];
  assign is_ctrl   = enc_mode & slot[8];
  assign force_en  = enc_mode & slot[9];
  assign disp_val  = enc_mode & ~pipe_mode & slot[10];
  assign elec_idle = enc_mode & pipe_mode & slot[10];
endmodule // twp_slice
`default_nettype wire

// >>> tb/twp_fabric_model.sv
// Fabric-side source of packed transmit words for the unpacker
`timescale 1ns/1ps
`default_nettype none
module twp_fabric_model (
  input  wire logic        pclk,
  input  wire logic        word_ready,
  output logic             word_valid,
  output logic      [21:0] word_data
);
  // Control flag is only ever raised on these K-character bytes
  localparam logic [7:0] KB [8] = '{8'h1c, 8'h3c, 8'h5c, 8'h7c,
                                    8'hbc, 8'hf7, 8'hfb, 8'hfe};

  initial begin
    word_valid = 1'b0;
    word_data  = 22'h0;
  end

  function automatic logic [21:0] make_word(input logic [3:0]  c,
                                            input logic [31:0] r);
    logic [21:0] w;
    w = r[21:0];
    if (w[8]) w[7:0] = KB[r[26:24]];
    if (w[19]) w[18:11] = KB[r[29:27]];
    case (c[1:0])
      2'd0:    w = w & 22'h0007ff;
      2'd1:    w = w & 22'h0003ff;
      2'd2:    if (c[3]) w[20] = 1'b0;
      default: w = w & 22'h1ffbff;
    endcase
    if (!c[2] && !c[0]) w = w & 22'h07f8ff;
    return w;
  endfunction

  // Holds the word for up to 200 edges, until word_ready is seen high at one
  task automatic send(input logic [21:0] w, output bit ok);
    int i;
    word_valid <= 1'b1;
    word_data  <= w;
    ok = 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge pclk);
      if (word_ready === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    word_valid <= 1'b0;
    // A released bus must not keep showing the last word
    word_data  <= ~w;
    @(posedge pclk);
  endtask
endmodule // twp_fabric_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the transmit word unpacker
`timescale 1ns/1ps
`default_nettype none
`include "twp_cfg.svh"
`define TB_CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  n_errors++; $display("wrong value at %0t: got %h exp %h", \
  $time, (g), (e)); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        word_valid, word_ready, sym_valid, sym_ready;
  logic [21:0] word_data;
  logic [9:0]  sym_data;
  logic        sym_ctrl, sym_force, sym_disp, sym_idle;
  logic [13:0] ex;
  logic [13:0] exq [$];
  logic        hold_rdy;
  int          n_errors, check_count;
  integer      seed = 32'h6ef7ec4a;
  localparam logic [3:0] MODES [8] = '{4'h4, 4'hc, 4'h1, 4'h6, 4'he, 4'h3,
                                       4'h0, 4'h2};

  twp_unpack uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .sym_valid(sym_valid), .sym_ready(sym_ready),
    .sym_data(sym_data), .sym_ctrl(sym_ctrl), .sym_force(sym_force),
    .sym_disp(sym_disp), .sym_idle(sym_idle));
  twp_fabric_model fab (.pclk(pclk), .word_ready(word_ready),
    .word_valid(word_valid), .word_data(word_data));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int i;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 100) begin
      n_errors++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic drain();
    logic [31:0] q;
    logic        e;
    int          i;
    for (i = 0; i < 400; i++) begin
      apb(1'b0, `TWP_OFF_STAT, 32'h0, q, e);
      if (q[3:1] === 3'b000) break;
    end
    `TB_CHK(q[3:1], 3'b000)
    if (q[3:1] !== 3'b000) stop_test();
  endtask

  // Expected characters: {idle, disp, force, ctrl, data}
  function automatic void expect_word(input logic [3:0]  c,
                                      input logic [21:0] w);
    logic k;
    logic p;
    logic idl;
    k   = c[2] & ~c[0];
    p   = c[3] & k;
    idl = p & (w[10] | (c[1] & w[21]));
    if (c[0]) begin
      exq.push_back({4'h0, w[9:0]});
      if (c[1]) exq.push_back({4'h0, w[20:11]});
    end else begin
      exq.push_back({idl, ~p & k & w[10], k & w[9], k & w[8], 2'b00,
                     w[7:0]});
      if (c[1]) exq.push_back({idl, ~p & k & w[21], ~p & k & w[20],
                               k & w[19], 2'b00, w[18:11]});
    end
  endfunction

  always @(posedge pclk) begin
    sym_ready <= hold_rdy ? 1'b0 : ($random(seed) % 4 != 0);
    if (presetn === 1'b1 && sym_valid === 1'b1 && sym_ready === 1'b1) begin
      ex = (exq.size() != 0) ? exq.pop_front() : 14'bx;
      `TB_CHK({sym_idle, sym_disp, sym_force, sym_ctrl, sym_data}, ex)
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    stop_test();
  end

  initial begin
    logic [31:0] q;
    logic        e;
    logic [21:0] w;
    logic [3:0]  c;
    bit          ok;
    int          m, i;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hold_rdy = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TWP_OFF_CFG, 32'h0, q, e);
    `TB_CHK(q, `TWP_CFG_RST)
    apb(1'b1, 12'h010, 32'hffff_ffff, q, e);
    apb(1'b0, 12'h010, 32'h0, q, e);
    `TB_CHK({e, q}, 33'h1_0000_0000)
    for (m = 0; m < 8; m++) begin
      c = MODES[m];
      apb(1'b1, `TWP_OFF_CFG, {28'h0, c}, q, e);
      apb(1'b1, `TWP_OFF_COUNT, 32'h0, q, e);
      for (i = 0; i < 24; i++) begin
        w = fab.make_word(c, $random(seed));
        expect_word(c, w);
        fab.send(w, ok);
        `TB_CHK(ok, 1'b1)
        if (!ok) stop_test();
      end
      drain();
      apb(1'b0, `TWP_OFF_COUNT, 32'h0, q, e);
      `TB_CHK(q, 32'd24)
      apb(1'b0, `TWP_OFF_LAST, 32'h0, q, e);
      `TB_CHK(q, {10'h0, w})
    end
    // Output stalled: the FIFO must fill to its depth and refuse
    hold_rdy = 1'b1;
    apb(1'b1, `TWP_OFF_CFG, 32'h4, q, e);
    for (i = 0; i < 40 && word_ready === 1'b1; i++) begin
      w = fab.make_word(4'h4, $random(seed));
      expect_word(4'h4, w);
      fab.send(w, ok);
      `TB_CHK(ok, 1'b1)
    end
    `TB_CHK(word_ready, 1'b0)
    apb(1'b0, `TWP_OFF_STAT, 32'h0, q, e);
    `TB_CHK(q[13:8], 6'd32)
    hold_rdy = 1'b0;
    drain();
    // Unassigned upper bits set on purpose: ignored, but flagged
    w = 22'h200041;
    expect_word(4'h4, w);
    fab.send(w, ok);
    drain();
    apb(1'b0, `TWP_OFF_STAT, 32'h0, q, e);
    `TB_CHK(q[0], 1'b1)
    apb(1'b1, `TWP_OFF_STAT, 32'h1, q, e);
    apb(1'b0, `TWP_OFF_STAT, 32'h0, q, e);
    `TB_CHK(q[0], 1'b0)
    `TB_CHK(exq.size(), 0)
    stop_test();
  end
endmodule // tb
`default_nettype wire
